// [fis_params.svh]
`ifndef FIS_PARAMS_SVH
`define FIS_PARAMS_SVH

`define FIS_AW          8
`define FIS_DW          16
`define FIS_NFAULT      2
`define FIS_NSYNC       3

`define ADDR_CTRL       8'h00
`define ADDR_STAT       8'h04
`define ADDR_ASTAT      8'h08
`define ADDR_MASK       8'h0C
`define ADDR_FAULT      8'h10
`define ADDR_SPOLL      8'h14
`define ADDR_CMD        8'h18
`define ADDR_SETP       8'h1C
`define ADDR_APPLIED    8'h20
`define ADDR_IRQ_MASK   8'h24

`define CTRL_ON         0
`define CTRL_HOLD       1
`define CTRL_SRQ        2

`define CMD_INIT        0
`define CMD_RST         1
`define CMD_TRG         2

`define BIT_RDIS        0
`define BIT_OV          1

`define SPOLL_FSUM      5
`define SPOLL_RQS       6

`define SYNC_RDIS       0
`define SYNC_OV         1
`define SYNC_TRG        2

`define FAULT_RST_VAL   2'h0
`define SETP_RST_VAL    16'h0000
`define SYNC_RST_VAL    3'h0

`endif

// [fis_pkg.sv]
`default_nettype none
package fis_pkg;
    typedef enum logic [1:0] {
        ST_OFF  = 2'h0,
        ST_ON   = 2'h1,
        ST_HALT = 2'h3
    } out_state_t;
endpackage
`default_nettype wire

// [sync_if.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fis_params.svh"
interface sync_if;
    logic [`FIS_NSYNC-1:0] raw;
    logic [`FIS_NSYNC-1:0] sync;
    modport sync_side (input raw, output sync);
    modport user_side (output raw, input sync);
endinterface
`default_nettype wire

// [input_sync.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fis_params.svh"
module input_sync (
    input  wire logic    clk_in,
    input  wire logic    rst_in,
    sync_if.sync_side    port
);
    genvar i;
    generate
        for (i = 0; i < `FIS_NSYNC; i++) begin : g_sync
            logic s1_r;
            logic s2_r;
            // two stages; s1_r feeds only s2_r
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else begin
                    s1_r <= port.raw[i];
                    s2_r <= s1_r;
                end
            end
            assign port.sync[i] = s2_r;
        end
    endgenerate
endmodule
`default_nettype wire

// [fault_inhibit_status_logic.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fis_params.svh"
module fault_inhibit_status_logic
    import fis_pkg::*;
(
    input  wire logic               clk_in,
    input  wire logic               rst_in,
    input  wire logic [`FIS_AW-1:0] addr_in,
    input  wire logic [`FIS_DW-1:0] wr_data_in,
    input  wire logic               wr_en_in,
    input  wire logic               rd_en_in,
    input  wire logic               remote_disable_in,
    input  wire logic               ovp_trip_in,
    input  wire logic               trigger_in,
    output logic [`FIS_DW-1:0]      rd_data_out,
    output logic                    output_enable_out,
    output logic [`FIS_DW-1:0]      setpoint_out,
    output logic                    fault_out_line_out,
    output logic                    srq_out,
    output logic                    irq_out
);
    function automatic logic hit(input logic en, input logic [`FIS_AW-1:0] a,
                                 input logic [`FIS_AW-1:0] off);
        return en && (a == off);
    endfunction

    sync_if sif ();
    logic [`FIS_NSYNC-1:0]  sync_q_r;
    logic [`FIS_NSYNC-1:0]  rise;
    logic [`FIS_NFAULT-1:0] fault_ev;
    logic [`FIS_NFAULT-1:0] live;
    logic [`FIS_NFAULT-1:0] astat_r;
    logic [`FIS_NFAULT-1:0] mask_r;
    logic [`FIS_NFAULT-1:0] irq_mask_r;
    logic [`FIS_NFAULT-1:0] fault_r;
    logic [`FIS_DW-1:0]     pend_r;
    logic [`FIS_DW-1:0]     appl_r;
    logic [`FIS_DW-1:0]     rd_val;
    logic [`FIS_DW-1:0]     rd_data_r;
    logic                   hold_r;
    logic                   srq_en_r;
    logic                   saved_on_r;
    logic                   rdis_s;
    logic                   init_cmd;
    logic                   rst_cmd;
    logic                   trg_cmd;
    logic                   soft_rst;
    logic                   ctrl_wr;
    logic                   setp_wr;
    logic                   fault_rd;
    logic                   fau_w;
    out_state_t             state_r;
    out_state_t             state_nxt;

    assign sif.raw = {trigger_in, ovp_trip_in, remote_disable_in};

    input_sync u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .port   (sif.sync_side)
    );

    // edge detect works on the second stage only
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync_q_r <= `SYNC_RST_VAL;
        end else begin
            sync_q_r <= sif.sync;
        end
    end

    assign rise     = sif.sync & ~sync_q_r;
    assign rdis_s   = sif.sync[`SYNC_RDIS];
    assign fault_ev = {rise[`SYNC_OV], rise[`SYNC_RDIS]};
    assign live     = {sif.sync[`SYNC_OV], rdis_s};
    assign ctrl_wr  = hit(wr_en_in, addr_in, `ADDR_CTRL);
    assign setp_wr  = hit(wr_en_in, addr_in, `ADDR_SETP);
    assign fault_rd = hit(rd_en_in, addr_in, `ADDR_FAULT);
    assign init_cmd = hit(wr_en_in, addr_in, `ADDR_CMD) && wr_data_in[`CMD_INIT];
    assign rst_cmd  = hit(wr_en_in, addr_in, `ADDR_CMD) && wr_data_in[`CMD_RST];
    assign trg_cmd  = (hit(wr_en_in, addr_in, `ADDR_CMD) && wr_data_in[`CMD_TRG])
                      || rise[`SYNC_TRG];
    // init command reuses the reset path; only the synchroniser, the edge-detect register and the read data register miss it
    assign soft_rst = rst_in || init_cmd;

    // ovp trips set status only, never the output state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_OFF: begin
                if (ctrl_wr && wr_data_in[`CTRL_ON] && !rdis_s) begin
                    state_nxt = ST_ON;
                end
            end
            ST_ON: begin
                if (ctrl_wr && !wr_data_in[`CTRL_ON]) begin
                    state_nxt = ST_OFF;
                end
            end
            ST_HALT: begin
                // release alone never leaves this state
                if (rst_cmd && fault_r == `FAULT_RST_VAL && !rdis_s) begin
                    state_nxt = saved_on_r ? ST_ON : ST_OFF;
                end else if (ctrl_wr && wr_data_in[`CTRL_ON] && !rdis_s) begin
                    state_nxt = ST_ON;
                end
            end
            default: begin
                state_nxt = ST_OFF;
            end
        endcase
        if (rise[`SYNC_RDIS]) begin
            state_nxt = ST_HALT;
        end
    end

    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            state_r <= ST_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    // remember whether the output was on before the first inhibit edge
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            saved_on_r <= 1'b0;
        end else if (rise[`SYNC_RDIS] && state_r != ST_HALT) begin
            saved_on_r <= (state_r == ST_ON);
        end
    end

    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            hold_r   <= 1'b0;
            srq_en_r <= 1'b0;
        end else if (ctrl_wr) begin
            hold_r   <= wr_data_in[`CTRL_HOLD];
            srq_en_r <= wr_data_in[`CTRL_SRQ];
        end
    end

    // a write in the trigger cycle is applied at once
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            pend_r <= `SETP_RST_VAL;
            appl_r <= `SETP_RST_VAL;
        end else begin
            if (setp_wr) begin
                pend_r <= wr_data_in;
            end
            if (setp_wr && (!hold_r || trg_cmd)) begin
                appl_r <= wr_data_in;
            end else if (trg_cmd) begin
                appl_r <= pend_r;
            end
        end
    end

    // sticky status: a new event beats a same-cycle clear
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            astat_r <= `FAULT_RST_VAL;
        end else begin
            astat_r <= (astat_r & ~(hit(wr_en_in, addr_in, `ADDR_ASTAT) ?
                        wr_data_in[`FIS_NFAULT-1:0] : `FAULT_RST_VAL)) | fault_ev;
        end
    end

    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            mask_r     <= `FAULT_RST_VAL;
            irq_mask_r <= `FAULT_RST_VAL;
        end else begin
            if (hit(wr_en_in, addr_in, `ADDR_MASK)) begin
                mask_r <= wr_data_in[`FIS_NFAULT-1:0];
            end
            if (hit(wr_en_in, addr_in, `ADDR_IRQ_MASK)) begin
                irq_mask_r <= wr_data_in[`FIS_NFAULT-1:0];
            end
        end
    end

    // read returns the old value; the clear lands after it
    always_ff @(posedge clk_in) begin
        if (soft_rst) begin
            fault_r <= `FAULT_RST_VAL;
        end else begin
            fault_r <= (fault_r & ~{`FIS_NFAULT{fault_rd}})
                       | (fault_ev & mask_r);
        end
    end

    // line follows the mask: clearing a mask bit drops it, the latch stays
    assign fault_out_line_out = |(fault_r & mask_r);
    assign fau_w              = |fault_r;
    assign srq_out            = fau_w && srq_en_r;
    assign irq_out            = |(astat_r & irq_mask_r);
    assign output_enable_out  = (state_r == ST_ON);
    assign setpoint_out       = appl_r;

    // setpoint readback shows the pending value, not the applied one
    always_comb begin
        rd_val = '0;
        unique case (addr_in)
            `ADDR_CTRL: begin
                rd_val[`CTRL_ON]   = output_enable_out;
                rd_val[`CTRL_HOLD] = hold_r;
                rd_val[`CTRL_SRQ]  = srq_en_r;
            end
            `ADDR_STAT:     rd_val[`FIS_NFAULT-1:0] = live;
            `ADDR_ASTAT:    rd_val[`FIS_NFAULT-1:0] = astat_r;
            `ADDR_MASK:     rd_val[`FIS_NFAULT-1:0] = mask_r;
            `ADDR_FAULT:    rd_val[`FIS_NFAULT-1:0] = fault_r;
            `ADDR_IRQ_MASK: rd_val[`FIS_NFAULT-1:0] = irq_mask_r;
            `ADDR_SPOLL: begin
                rd_val[`SPOLL_FSUM] = fau_w;
                rd_val[`SPOLL_RQS] = srq_out;
            end
            `ADDR_SETP:     rd_val = pend_r;
            `ADDR_APPLIED:  rd_val = appl_r;
            default:        rd_val = '0;
        endcase
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= rd_en_in ? rd_val : '0;
        end
    end

    assign rd_data_out = rd_data_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    chk_halt_disables: assert property (
        (rise[`SYNC_RDIS] && !init_cmd) |=> (state_r == ST_HALT) && !output_enable_out)
        else $error("inhibit did not turn the output off");

    chk_rdis_accum: assert property (
        (rise[`SYNC_RDIS] && !init_cmd) |=> astat_r[`BIT_RDIS])
        else $error("remote-disable bit not accumulated");

    chk_rdis_live: assert property (
        (hit(rd_en_in, addr_in, `ADDR_STAT) && rdis_s) |=> rd_data_out[`BIT_RDIS])
        else $error("live remote-disable bit missing");

    chk_live_clear: assert property (
        (hit(rd_en_in, addr_in, `ADDR_STAT) && !rdis_s) |=> !rd_data_out[`BIT_RDIS])
        else $error("live remote-disable bit stuck");

    chk_halt_fault_line: assert property (
        (rise[`SYNC_RDIS] && mask_r[`BIT_RDIS] && !init_cmd
         && !hit(wr_en_in, addr_in, `ADDR_MASK)) |=> fault_out_line_out)
        else $error("unmasked inhibit did not raise the fault line");

    chk_fault_latch: assert property (
        (rise[`SYNC_RDIS] && mask_r[`BIT_RDIS] && !init_cmd) |=> fault_r[`BIT_RDIS] && fau_w)
        else $error("fault bit or summary not set");

    chk_spoll_summary: assert property (
        (hit(rd_en_in, addr_in, `ADDR_SPOLL) && fault_r != `FAULT_RST_VAL) |=> rd_data_out[`SPOLL_FSUM])
        else $error("serial-poll summary bit missing");

    chk_release_off: assert property (
        (state_r == ST_HALT && !rst_cmd && !init_cmd && !ctrl_wr) |=> !output_enable_out)
        else $error("output re-enabled without a command");

    // refused commands leave the output where it was
    chk_on_refused: assert property (
        (ctrl_wr && rdis_s && state_r != ST_ON && !init_cmd) |=> !output_enable_out)
        else $error("output turned on while inhibit is high");

    chk_read_clears: assert property (
        (fault_rd && fault_ev == `FAULT_RST_VAL) |=> (fault_r == `FAULT_RST_VAL) && !fault_out_line_out)
        else $error("fault read did not clear the fault");

    chk_init_state: assert property (
        init_cmd |=> (state_r == ST_OFF) && (mask_r == `FAULT_RST_VAL)
                     && (fault_r == `FAULT_RST_VAL) && (appl_r == `SETP_RST_VAL) && !hold_r)
        else $error("init command left state behind");

    chk_masked_quiet: assert property (
        (mask_r == `FAULT_RST_VAL) |-> !fault_out_line_out)
        else $error("masked fault drives the fault line");

    chk_masked_latch: assert property (
        (fault_ev != `FAULT_RST_VAL && (fault_ev & mask_r) == `FAULT_RST_VAL && !fault_rd && !init_cmd)
        |=> (fault_r == $past(fault_r)))
        else $error("masked fault was latched");

    chk_restore_on: assert property (
        (state_r == ST_HALT && saved_on_r && rst_cmd && fault_r == `FAULT_RST_VAL
         && !rdis_s && !rise[`SYNC_RDIS] && !init_cmd) |=> output_enable_out)
        else $error("reset command did not restore the output");

    chk_rst_refused: assert property (
        (state_r == ST_HALT && rst_cmd && fault_r != `FAULT_RST_VAL && !init_cmd) |=> (state_r == ST_HALT))
        else $error("reset command accepted with a fault latched");

    chk_srq_raise: assert property (
        (rise[`SYNC_RDIS] && mask_r[`BIT_RDIS] && srq_en_r && !init_cmd && !ctrl_wr) |=> srq_out)
        else $error("latched fault raised no service request");

    chk_hold_keeps: assert property (
        (setp_wr && hold_r && !trg_cmd && !init_cmd) |=> (appl_r == $past(appl_r)))
        else $error("held setting applied without trigger");

    chk_trig_applies: assert property (
        (trg_cmd && !setp_wr && !init_cmd) |=> (appl_r == $past(pend_r)))
        else $error("trigger did not apply the held setting");

    chk_sync_depth: assert property (
        $rose(rdis_s) |-> $past(remote_disable_in, 2))
        else $error("inhibit reached logic too early");

    // covers mark the main scenarios
    cov_halt_event:  cover property (rise[`SYNC_RDIS] && mask_r[`BIT_RDIS]);
    cov_restore:     cover property (state_r == ST_HALT ##[1:200] state_r == ST_ON);
    cov_trigger:     cover property (hold_r && setp_wr ##[1:50] trg_cmd);
    cov_read_set:    cover property (fault_rd && fault_ev != `FAULT_RST_VAL);
    cov_rst_refused: cover property (state_r == ST_HALT && rst_cmd && fault_r != `FAULT_RST_VAL);
endmodule
`default_nettype wire

// [inhibit_source.sv]
`timescale 1ns/1ps
`default_nettype none
module inhibit_source (
    input  wire logic clk_in,
    input  wire logic hood_open_in,
    input  wire logic ovp_req_in,
    input  wire logic trig_req_in,
    output logic      remote_disable_out,
    output logic      ovp_trip_out,
    output logic      trigger_out
);
    initial begin
        remote_disable_out = 1'b0;
        ovp_trip_out = 1'b0;
        trigger_out = 1'b0;
    end
    // pins move 3 ns after the edge: never aligned to the block clock
    always @(posedge clk_in) begin
        #3;
        remote_disable_out = hood_open_in;
        ovp_trip_out = ovp_req_in;
        trigger_out = trig_req_in;
    end
endmodule
`default_nettype wire

// [fault_inhibit_status_logic_test.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fis_params.svh"
module fault_inhibit_status_logic_test;
    logic               clk_in;
    logic               rst_in = 1'b1;
    logic               wr_en_in = 1'b0;
    logic               rd_en_in = 1'b0;
    logic [`FIS_AW-1:0] addr_in = '0;
    logic [`FIS_DW-1:0] wr_data_in = '0;
    logic               hood = 1'b0;
    logic               ovp_req = 1'b0;
    logic               trig_req = 1'b0;
    logic               pin_rdis;
    logic               pin_ovp;
    logic               pin_trg;
    logic [`FIS_DW-1:0] rd_data_out;
    logic               output_enable_out;
    logic [`FIS_DW-1:0] setpoint_out;
    logic               fault_out_line_out;
    logic               srq_out;
    logic               irq_out;
    logic               rd_pend = 1'b0;
    logic [15:0]        exp_q[$];
    logic [15:0]        exp_v;
    logic [15:0]        v1;
    logic [15:0]        v2;
    logic [15:0]        v3;
    int                 fails = 0;
    int                 n_compared = 0;
    int                 cyc = 0;
    int                 seed;

    fault_inhibit_status_logic dut (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
        .wr_en_in(wr_en_in), .rd_en_in(rd_en_in), .remote_disable_in(pin_rdis),
        .ovp_trip_in(pin_ovp), .trigger_in(pin_trg), .rd_data_out(rd_data_out),
        .output_enable_out(output_enable_out), .setpoint_out(setpoint_out),
        .fault_out_line_out(fault_out_line_out), .srq_out(srq_out), .irq_out(irq_out)
    );

    inhibit_source far_side (
        .clk_in(clk_in), .hood_open_in(hood), .ovp_req_in(ovp_req), .trig_req_in(trig_req),
        .remote_disable_out(pin_rdis), .ovp_trip_out(pin_ovp), .trigger_out(pin_trg)
    );

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one strobe cycle, then a quiet edge so no signal is driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        exp_q.push_back(exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
    endtask

    task automatic pin_wait(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    // pin held three cycles so the synchroniser surely sees the rise
    task automatic pulse(input logic sel);
        @(posedge clk_in);
        ovp_req <= sel;
        trig_req <= ~sel;
        repeat (3) @(posedge clk_in);
        ovp_req <= 1'b0;
        trig_req <= 1'b0;
        pin_wait(4);
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk_in) begin
        if (rd_pend) begin
            exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
            check_val(rd_data_out, exp_v, "read data");
        end
        rd_pend <= rd_en_in;
    end

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails = fails + 1;
            summarize();
        end
    end

    initial begin
        seed = $urandom(32'hAB3B);
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        pin_wait(1);
        check_val(output_enable_out, 16'h0000, "reset oe");
        rd(`ADDR_CTRL, 16'h0000);
        rd(8'h30, 16'h0000);
        $display("test reset done");

        wr(`ADDR_MASK, 16'h0001);
        wr(`ADDR_IRQ_MASK, 16'h0001);
        wr(`ADDR_CTRL, 16'h0005);
        check_val(output_enable_out, 16'h0001, "oe on");
        @(posedge clk_in);
        hood <= 1'b1;
        pin_wait(2);
        check_val(output_enable_out, 16'h0001, "oe before sync");
        pin_wait(2);
        check_val(output_enable_out, 16'h0000, "oe inhibit");
        check_val(fault_out_line_out, 16'h0001, "fault line");
        check_val(srq_out, 16'h0001, "srq");
        check_val(irq_out, 16'h0001, "irq");
        rd(`ADDR_STAT, 16'h0001);
        rd(`ADDR_ASTAT, 16'h0001);
        rd(`ADDR_SPOLL, 16'h0060);
        wr(`ADDR_CTRL, 16'h0005);
        check_val(output_enable_out, 16'h0000, "on refused");
        @(posedge clk_in);
        hood <= 1'b0;
        pin_wait(4);
        check_val(output_enable_out, 16'h0000, "oe release");
        rd(`ADDR_STAT, 16'h0000);
        wr(`ADDR_CMD, 16'h0002);
        check_val(output_enable_out, 16'h0000, "restore early");
        rd(`ADDR_FAULT, 16'h0001);
        check_val(fault_out_line_out, 16'h0000, "line cleared");
        rd(`ADDR_FAULT, 16'h0000);
        wr(`ADDR_CMD, 16'h0002);
        check_val(output_enable_out, 16'h0001, "restore");
        wr(`ADDR_ASTAT, 16'h0001);
        check_val(irq_out, 16'h0000, "irq clear");
        $display("test inhibit done");

        pulse(1'b1);
        check_val(fault_out_line_out, 16'h0000, "masked ovp");
        check_val(output_enable_out, 16'h0001, "ovp keeps on");
        check_val(irq_out, 16'h0000, "irq masked");
        wr(`ADDR_MASK, 16'h0003);
        wr(`ADDR_IRQ_MASK, 16'h0002);
        check_val(irq_out, 16'h0001, "irq ovp");
        pulse(1'b1);
        check_val(fault_out_line_out, 16'h0001, "unmasked ovp");
        rd(`ADDR_FAULT, 16'h0002);
        wr(`ADDR_ASTAT, 16'h0003);
        rd(`ADDR_ASTAT, 16'h0000);
        $display("test mask done");

        v1 = 16'($urandom);
        v2 = ~v1;
        v3 = 16'($urandom);
        wr(`ADDR_SETP, v1);
        check_val(setpoint_out, v1, "direct apply");
        wr(`ADDR_CTRL, 16'h0003);
        wr(`ADDR_SETP, v2);
        check_val(setpoint_out, v1, "held");
        rd(`ADDR_APPLIED, v1);
        pulse(1'b0);
        check_val(setpoint_out, v2, "pin trigger");
        wr(`ADDR_SETP, v3);
        wr(`ADDR_CMD, 16'h0004);
        check_val(setpoint_out, v3, "cmd trigger");
        wr(`ADDR_APPLIED, 16'h0000);
        rd(`ADDR_APPLIED, v3);
        $display("test hold done");

        wr(`ADDR_CMD, 16'h0001);
        check_val(output_enable_out, 16'h0000, "init oe");
        check_val(setpoint_out, 16'h0000, "init setp");
        rd(`ADDR_MASK, 16'h0000);
        rd(`ADDR_CTRL, 16'h0000);
        rd(`ADDR_SETP, 16'h0000);
        pin_wait(3);
        $display("test init done");
        summarize();
    end
endmodule
`default_nettype wire
